// >>> hdl/pmrc_pkg.sv
// Constants, register map and types of the program memory read controller.
// Assumes one clock, where one clock cycle stands for one instruction cycle.
`default_nettype none

package pmrc_pkg;

  // ---------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------
  localparam int PMRC_WORD_W    = 14;  // Width of one program word.
  localparam int PMRC_ADDR_W    = 12;  // Width of the fetch address.
  localparam int PMRC_HI_USED   = 4;   // Address high byte bits in use.
  localparam int PMRC_APB_AW    = 12;  // Width of the APB byte address.
  localparam int PMRC_RD_BIT    = 0;   // Position of the read trigger.
  localparam int PMRC_HI_DATA_W = 6;   // Word bits held in the high byte.

  // ---------------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ---------------------------------------------------------------------
  localparam logic [11:0] PMRC_IDX_DATA_LO = 12'h10C;
  localparam logic [11:0] PMRC_IDX_ADDR_LO = 12'h10D;
  localparam logic [11:0] PMRC_IDX_DATA_HI = 12'h10E;
  localparam logic [11:0] PMRC_IDX_ADDR_HI = 12'h10F;
  localparam logic [11:0] PMRC_IDX_CONTROL = 12'h18C;

  localparam logic [11:0] PMRC_BA_DATA_LO = {PMRC_IDX_DATA_LO[9:0], 2'b00};
  localparam logic [11:0] PMRC_BA_ADDR_LO = {PMRC_IDX_ADDR_LO[9:0], 2'b00};
  localparam logic [11:0] PMRC_BA_DATA_HI = {PMRC_IDX_DATA_HI[9:0], 2'b00};
  localparam logic [11:0] PMRC_BA_ADDR_HI = {PMRC_IDX_ADDR_HI[9:0], 2'b00};
  localparam logic [11:0] PMRC_BA_CONTROL = {PMRC_IDX_CONTROL[9:0], 2'b00};

  // ---------------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------------
  localparam logic [7:0]  PMRC_RST_BYTE = 8'h00;
  localparam logic [31:0] PMRC_RST_WORD = 32'h0000_0000;

  // Cycles from the trigger write to the read slot.
  localparam int PMRC_SLOT_DELAY = 2;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {PMRC_IDLE, PMRC_EXEC, PMRC_READ} pmrc_state_e;

  typedef enum logic [2:0] {
    PMRC_SEL_NONE, PMRC_SEL_DLO, PMRC_SEL_ALO,
    PMRC_SEL_DHI, PMRC_SEL_AHI, PMRC_SEL_CTL
  } pmrc_sel_e;

endpackage : pmrc_pkg

`default_nettype wire

// >>> hdl/pmrc_seq_if.sv
// Carrier between the register block and the read sequencer.
// Assumes both ends run on the same clock.
`default_nettype none

interface pmrc_seq_if;
  logic start;      // One-cycle request to begin a read.
  logic busy;       // A read is in flight.
  logic read_slot;  // The cycle taken over for the memory access.
  logic done;       // Last cycle of the read; data is captured at its end.

  modport seq (input start, output busy, output read_slot, output done);
  modport ctl (output start, input busy, input read_slot, input done);
endinterface : pmrc_seq_if

`default_nettype wire

// >>> hdl/pmrc_seq.sv
// Read sequencer: counts the instruction slots after a trigger.
// Assumes start is only raised while busy is low.
`default_nettype none

module pmrc_seq
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Link to the register block
  pmrc_seq_if.seq  SQ
);
  import pmrc_pkg::*;

  pmrc_state_e state_q;
  pmrc_state_e state_d;

  // Next state: one slot for the following instruction, then the read.
  always_comb begin
    state_d = state_q;
    case (state_q)
      PMRC_IDLE: begin
        if (SQ.start) begin
          state_d = PMRC_EXEC;
        end
      end
      PMRC_EXEC: state_d = PMRC_READ;
      PMRC_READ: state_d = PMRC_IDLE;
      default:   state_d = PMRC_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_q <= PMRC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // The read slot is also the completing cycle, so done equals it.
  assign SQ.busy      = (state_q != PMRC_IDLE);
  assign SQ.read_slot = (state_q == PMRC_READ);
  assign SQ.done      = (state_q == PMRC_READ);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_seq_back_idle: assert property (SQ.read_slot |=> !SQ.busy)
    else $error("sequencer did not return to idle after the read slot");

endmodule : pmrc_seq

`default_nettype wire

// >>> hdl/pmrc_top.sv
// Program memory read controller with an APB register slave.
// Assumes one clock cycle per instruction cycle, and a program memory that
// returns the word combinationally while MEM_RD is high.
`default_nettype none

// Operation
// - Each 14-bit fetched word spans two byte-wide data registers.
// - The 12-bit fetch address joins the high and low address bytes.
// - Address high byte bits beyond the implemented memory are ignored.
// - Software can set but not clear the trigger; completion clears it.
// - The second instruction cycle after the trigger is used for the read.
// - The second instruction after the trigger is dropped, not the first.
// - The word is in both data registers in the cycle after the read slot.
// - The data registers keep the word until the next read or a write.
// - The high data register carries word bits 13 to 8 in its bits 5 to 0.
// - Reads proceed normally while code protection is active.
module pmrc_top
(
  // Clock and reset
  input  wire logic                              CLK,
  input  wire logic                              RESET,
  // APB slave
  input  wire logic                              PSEL,
  input  wire logic                              PENABLE,
  input  wire logic                              PWRITE,
  input  wire logic [pmrc_pkg::PMRC_APB_AW-1:0]  PADDR,
  input  wire logic [31:0]                       PWDATA,
  output var  logic [31:0]                       PRDATA,
  output var  logic                              PREADY,
  output var  logic                              PSLVERR,
  // Program memory array
  output var  logic [pmrc_pkg::PMRC_ADDR_W-1:0]  MEM_ADDR,
  output var  logic                              MEM_RD,
  input  wire logic [pmrc_pkg::PMRC_WORD_W-1:0]  MEM_DATA,
  // Processor core
  input  wire logic                              CODE_PROTECT,
  output var  logic                              SUPPRESS_EXEC
);
  import pmrc_pkg::*;

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  logic [7:0]  data_lo_q;
  logic [7:0]  data_hi_q;
  logic [7:0]  addr_lo_q;
  logic [7:0]  addr_hi_q;
  logic        trig_q;
  logic [31:0] prdata_q;
  logic        setup_rd;
  logic        acc;
  logic        wr_acc;
  pmrc_sel_e   sel;

  pmrc_seq_if sq ();

  // -----------------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------------

  // Maps a byte address to a register; used by both read and write paths.
  function automatic pmrc_sel_e sel_of(input logic [PMRC_APB_AW-1:0] a);
    pmrc_sel_e s;
    s = PMRC_SEL_NONE;
    case (a)
      PMRC_BA_DATA_LO: s = PMRC_SEL_DLO;
      PMRC_BA_ADDR_LO: s = PMRC_SEL_ALO;
      PMRC_BA_DATA_HI: s = PMRC_SEL_DHI;
      PMRC_BA_ADDR_HI: s = PMRC_SEL_AHI;
      PMRC_BA_CONTROL: s = PMRC_SEL_CTL;
      default:         s = PMRC_SEL_NONE;
    endcase
    return s;
  endfunction : sel_of

  // Bus phases; the slave never inserts wait states.
  assign sel      = sel_of(PADDR);
  assign setup_rd = PSEL && !PENABLE && !PWRITE;
  assign acc      = PSEL && PENABLE;
  assign wr_acc   = acc && PWRITE;

  // -----------------------------------------------------------------------
  // APB answer
  // -----------------------------------------------------------------------

  // Handshake outputs are combinational; unmapped addresses flag an error.
  assign PREADY  = 1'b1;
  assign PSLVERR = acc && (sel == PMRC_SEL_NONE);

  // Read data is sampled in the setup cycle so PRDATA comes from a flop
  // and is steady through the access cycle.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      prdata_q <= PMRC_RST_WORD;
    end else if (setup_rd) begin
      case (sel)
        PMRC_SEL_DLO: prdata_q <= {24'h00_0000, data_lo_q};
        PMRC_SEL_ALO: prdata_q <= {24'h00_0000, addr_lo_q};
        PMRC_SEL_DHI: prdata_q <= {24'h00_0000, data_hi_q};
        PMRC_SEL_AHI: prdata_q <= {24'h00_0000, addr_hi_q};
        PMRC_SEL_CTL: prdata_q <= {31'h0000_0000, trig_q};
        default:      prdata_q <= PMRC_RST_WORD;
      endcase
    end
  end

  assign PRDATA = prdata_q;

  // -----------------------------------------------------------------------
  // Address registers
  // -----------------------------------------------------------------------

  // Both bytes are plain storage; a change during a read in flight takes
  // effect for that read only if it lands before the read slot.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      addr_lo_q <= PMRC_RST_BYTE;
    end else if (wr_acc && sel == PMRC_SEL_ALO) begin
      addr_lo_q <= PWDATA[7:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      addr_hi_q <= PMRC_RST_BYTE;
    end else if (wr_acc && sel == PMRC_SEL_AHI) begin
      addr_hi_q <= PWDATA[7:0];
    end
  end

  // The high byte reads back whole, but only its low bits reach memory.
  assign MEM_ADDR = {addr_hi_q[PMRC_HI_USED-1:0], addr_lo_q};

  // -----------------------------------------------------------------------
  // Read trigger
  // -----------------------------------------------------------------------

  // A write of one to the trigger bit starts a read unless one is running.
  assign sq.start = wr_acc && (sel == PMRC_SEL_CTL)
                    && PWDATA[PMRC_RD_BIT] && !trig_q;

  // Writing zero never clears the bit; only completion does.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      trig_q <= 1'b0;
    end else if (sq.done) begin
      trig_q <= 1'b0;
    end else if (sq.start) begin
      trig_q <= 1'b1;
    end
  end

  // -----------------------------------------------------------------------
  // Sequencer and memory access
  // -----------------------------------------------------------------------

  // Timing of one read, counted in instruction cycles from the edge that
  // takes the trigger write:
  //   cycle 1  the instruction after the trigger runs as usual;
  //   cycle 2  MEM_RD and SUPPRESS_EXEC are high and the word is fetched;
  //   cycle 3  both data registers hold the word and the trigger reads 0.
  // The address bytes are not latched at the trigger, so a write to them
  // before cycle 2 changes the location that is read.
  pmrc_seq pmrc_seq_inst (
    .CLK   (CLK),
    .RESET (RESET),
    .SQ    (sq.seq)
  );

  // Code protection only guards external readout, so it does not gate the
  // internal fetch; the input is kept for the checks below.
  assign MEM_RD        = sq.read_slot;
  assign SUPPRESS_EXEC = sq.read_slot;

  // -----------------------------------------------------------------------
  // Data registers
  // -----------------------------------------------------------------------

  // The fetched word wins over a software write in the same cycle, so a
  // completed read is never lost.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      data_lo_q <= PMRC_RST_BYTE;
    end else if (sq.done) begin
      data_lo_q <= MEM_DATA[7:0];
    end else if (wr_acc && sel == PMRC_SEL_DLO) begin
      data_lo_q <= PWDATA[7:0];
    end
  end

  // Bits 7 and 6 are never stored as ones, so they always read zero.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      data_hi_q <= PMRC_RST_BYTE;
    end else if (sq.done) begin
      data_hi_q <= {2'b00, MEM_DATA[PMRC_WORD_W-1:8]};
    end else if (wr_acc && sel == PMRC_SEL_DHI) begin
      data_hi_q <= {2'b00, PWDATA[PMRC_HI_DATA_W-1:0]};
    end
  end

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_slot_timing: assert property (sq.start |-> ##2 MEM_RD)
    else $error("memory read did not use the second cycle after trigger");

  a_next_runs: assert property (
    sq.start |=> !SUPPRESS_EXEC ##1 SUPPRESS_EXEC ##1 !SUPPRESS_EXEC)
    else $error("wrong instruction slot suppressed after trigger");

  a_trig_life: assert property (
    sq.start |=> trig_q ##1 trig_q ##1 !trig_q)
    else $error("read trigger not held then cleared at completion");

  a_sw_noclear: assert property (
    (trig_q && !sq.done && wr_acc && sel == PMRC_SEL_CTL
     && !PWDATA[PMRC_RD_BIT]) |=> trig_q)
    else $error("software write cleared the read trigger");

  a_word_loaded: assert property (
    MEM_RD |=> {data_hi_q[PMRC_HI_DATA_W-1:0], data_lo_q}
               == $past(MEM_DATA))
    else $error("fetched word not in data registers after read slot");

  a_data_hold: assert property (
    (!sq.done && !(wr_acc && (sel == PMRC_SEL_DLO || sel == PMRC_SEL_DHI)))
    |=> $stable(data_lo_q) && $stable(data_hi_q))
    else $error("data registers changed without a read or a write");

  a_hi_zero: assert property (data_hi_q[7:6] == 2'b00)
    else $error("unused high data bits not zero");

  a_addr_mask: assert property (
    MEM_RD |-> MEM_ADDR[PMRC_ADDR_W-1:8] == addr_hi_q[PMRC_HI_USED-1:0])
    else $error("memory address not taken from used high byte bits");

  a_protect_reads: assert property (
    (sq.start && CODE_PROTECT) |-> ##2 MEM_RD)
    else $error("code protection blocked a program memory read");

  a_ctl_readback: assert property (
    (setup_rd && sel == PMRC_SEL_CTL) |=> PRDATA == {31'h0000_0000,
                                                     $past(trig_q)})
    else $error("control register read does not show the trigger");

  // -----------------------------------------------------------------------
  // Checks on the sequencer link
  // -----------------------------------------------------------------------

  // The trigger bit and the busy flag must agree, or a second trigger
  // could slip in while the first read is still in flight.
  a_busy_trig: assert property (sq.busy == trig_q)
    else $error("trigger bit and sequencer busy flag disagree");

  // A read slot without a pending trigger would fetch a stale address.
  a_slot_needs_trig: assert property (MEM_RD |-> trig_q)
    else $error("memory read without a pending trigger");

  // The slot is a single instruction cycle; a longer one would drop a
  // second instruction that the core expects to run.
  a_slot_single: assert property (MEM_RD |=> !MEM_RD)
    else $error("read slot lasted more than one cycle");

  a_drop_is_slot: assert property (SUPPRESS_EXEC == MEM_RD)
    else $error("dropped instruction slot is not the read slot");

  a_start_idle: assert property (sq.start |-> !sq.busy)
    else $error("read started while another was in flight");

  // Only an accepted trigger write may raise the bit.
  a_trig_set_only: assert property (
    (!sq.start && !trig_q) |=> !trig_q)
    else $error("read trigger rose without an accepted write");

  a_done_clears: assert property (sq.done |=> !trig_q)
    else $error("read trigger not cleared at completion");

  // Protection must not blank the word that an in-flight read loads.
  a_protect_data: assert property (
    (MEM_RD && CODE_PROTECT) |=> data_lo_q == $past(MEM_DATA[7:0]))
    else $error("code protection blocked the fetched word");

  // -----------------------------------------------------------------------
  // Checks on the register writes
  // -----------------------------------------------------------------------

  // Address bytes take a write at the access edge and nothing else moves
  // them, so the read slot sees the address that software left.
  a_addr_lo_write: assert property (
    (wr_acc && sel == PMRC_SEL_ALO) |=> addr_lo_q == $past(PWDATA[7:0]))
    else $error("address low byte did not take the write");

  a_addr_hi_write: assert property (
    (wr_acc && sel == PMRC_SEL_AHI) |=> addr_hi_q == $past(PWDATA[7:0]))
    else $error("address high byte did not take the write");

  a_addr_hold: assert property (
    !(wr_acc && (sel == PMRC_SEL_ALO || sel == PMRC_SEL_AHI))
    |=> $stable(addr_lo_q) && $stable(addr_hi_q))
    else $error("address bytes changed without a write");

  // A software write lands only when no fetched word is being loaded.
  a_data_lo_write: assert property (
    (wr_acc && sel == PMRC_SEL_DLO && !sq.done)
    |=> data_lo_q == $past(PWDATA[7:0]))
    else $error("data low byte did not take the write");

  a_data_hi_write: assert property (
    (wr_acc && sel == PMRC_SEL_DHI && !sq.done)
    |=> data_hi_q == {2'b00, $past(PWDATA[PMRC_HI_DATA_W-1:0])})
    else $error("data high byte did not take the write");

  // -----------------------------------------------------------------------
  // Checks on the read-back path
  // -----------------------------------------------------------------------

  // Software reads the word back a byte at a time, so each byte must
  // come out of the bus unaltered and with zeros above it.
  a_rd_data_lo: assert property (
    (setup_rd && sel == PMRC_SEL_DLO)
    |=> PRDATA == {24'h00_0000, $past(data_lo_q)})
    else $error("data low byte read back wrongly");

  a_rd_data_hi: assert property (
    (setup_rd && sel == PMRC_SEL_DHI)
    |=> PRDATA == {24'h00_0000, $past(data_hi_q)})
    else $error("data high byte read back wrongly");

  a_rd_addr_lo: assert property (
    (setup_rd && sel == PMRC_SEL_ALO)
    |=> PRDATA == {24'h00_0000, $past(addr_lo_q)})
    else $error("address low byte read back wrongly");

  a_rd_addr_hi: assert property (
    (setup_rd && sel == PMRC_SEL_AHI)
    |=> PRDATA == {24'h00_0000, $past(addr_hi_q)})
    else $error("address high byte did not read back whole");

endmodule : pmrc_top

`default_nettype wire

// >>> verification/pmrc_mem_model.sv
// Behavioural model of the program memory array behind the controller.
// Assumes one clock and that the controller holds MEM_ADDR during MEM_RD.
`default_nettype none

module pmrc_mem_model (
  // Clock
  input  wire logic        CLK,
  // Fetch side
  input  wire logic [11:0] MEM_ADDR,
  input  wire logic        MEM_RD,
  output var  logic [13:0] MEM_DATA
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [13:0] last_q = 14'h0155;

  // Off the read slot the lines toggle every cycle, so a late or early
  // capture can never pick up a plausible stale word.
  always_comb begin
    if (MEM_RD) begin
      MEM_DATA = ({2'b00, MEM_ADDR} * 14'h01B3) ^ 14'h2C5A;
    end else begin
      MEM_DATA = ~last_q;
    end
  end

  // Remember what was shown for the next inversion.
  always_ff @(posedge CLK) begin
    last_q <= MEM_DATA;
  end
endmodule : pmrc_mem_model

`default_nettype wire

// >>> verification/tb_pmrc_top.sv
// Self-checking bench of the program memory read controller.
// Assumes the memory model answers combinationally while MEM_RD is high.
`default_nettype none

module tb_pmrc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pmrc_pkg::*;

  logic        CLK = 1'b0;
  logic        RESET = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic        CODE_PROTECT = 1'b0;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic [11:0] MEM_ADDR;
  logic        MEM_RD;
  logic [13:0] MEM_DATA;
  logic        SUPPRESS_EXEC;
  int          n_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [32:0] exp_q [$];
  logic [1:0]  sh_q = 2'b00;
  logic [11:0] exp_addr = 12'h000;
  logic [31:0] seed = 32'h4789;
  logic [11:0] ba [5] = '{PMRC_BA_DATA_LO, PMRC_BA_ADDR_LO, PMRC_BA_DATA_HI,
                          PMRC_BA_ADDR_HI, PMRC_BA_CONTROL};

  pmrc_top pmrc_top_inst (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_DATA(MEM_DATA),
    .CODE_PROTECT(CODE_PROTECT), .SUPPRESS_EXEC(SUPPRESS_EXEC));

  pmrc_mem_model pmrc_mem_model_inst (.CLK(CLK), .MEM_ADDR(MEM_ADDR),
    .MEM_RD(MEM_RD), .MEM_DATA(MEM_DATA));

  always #5 CLK = ~CLK;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (!ok) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk

  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // One APB transfer, entered just after an edge; psel stays up so that
  // transfers chain back to back, and the caller drops it when pausing.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    PENABLE <= 1'b0;
  endtask : apb

  // A read notes {error, data} it expects; the monitor compares it.
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Tracks the two slots after an accepted trigger and checks reads.
  always @(posedge CLK) begin
    if (RESET) sh_q <= 2'b00;
    else sh_q <= {sh_q[0], PSEL & PENABLE & PWRITE & PREADY & PWDATA[0]
                  & (PADDR == PMRC_BA_CONTROL) & (sh_q == 2'b00)};
    if (!RESET && PSEL && PENABLE && !PWRITE && PREADY)
      chk(exp_q.size() > 0 && {PSLVERR, PRDATA} === exp_q.pop_front(),
          "read value");
    // Writes answer without error unless nothing is mapped at the address.
    if (!RESET && PSEL && PENABLE && PWRITE && PREADY)
      chk(PSLVERR === (PADDR == 12'h000), "write error flag");
  end

  // The slot and its address are judged mid-cycle, once settled.
  always @(negedge CLK) begin
    if (!RESET) begin
      chk(MEM_RD === sh_q[1], "read slot");
      chk(SUPPRESS_EXEC === sh_q[1], "dropped slot");
      if (sh_q[1]) chk(MEM_ADDR === exp_addr, "fetch address");
    end
  end

  // Cuts a hang short; a full run needs well under 400 cycles.
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      end_sim;
    end
  end

  initial begin
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [13:0] w;
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    foreach (ba[i]) rd(ba[i], 33'h0);
    $display("test reset values done");
    // Random addresses, the last one all ones, protection toggled.
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      {hi, lo} = (i == 7) ? 16'hFFFF : seed[15:0];
      CODE_PROTECT <= i[0];
      apb(1'b1, PMRC_BA_ADDR_HI, {24'h0, hi});
      apb(1'b1, PMRC_BA_ADDR_LO, {24'h0, lo});
      exp_addr = {hi[3:0], lo};
      w = ({2'b00, exp_addr} * 14'h01B3) ^ 14'h2C5A;
      apb(1'b1, PMRC_BA_CONTROL, 32'h1);
      // This read stands in for the plain slot and the dropped one.
      rd(PMRC_BA_CONTROL, 33'h1);
      rd(PMRC_BA_DATA_LO, {25'h0, w[7:0]});
      rd(PMRC_BA_DATA_HI, {27'h0, w[13:8]});
      rd(PMRC_BA_CONTROL, 33'h0);
      rd(PMRC_BA_ADDR_HI, {25'h0, hi});
    end
    $display("test program reads done");
    apb(1'b1, PMRC_BA_CONTROL, 32'h0);
    rd(PMRC_BA_DATA_LO, {25'h0, w[7:0]});
    apb(1'b1, PMRC_BA_DATA_LO, 32'h1A5);
    apb(1'b1, PMRC_BA_DATA_HI, 32'hFF);
    rd(PMRC_BA_DATA_LO, 33'hA5);
    rd(PMRC_BA_DATA_HI, 33'h3F);
    $display("test data hold done");
    apb(1'b1, 12'h000, 32'hFF);
    rd(12'h000, 33'h1_0000_0000);
    rd(PMRC_BA_DATA_HI, 33'h3F);
    PSEL <= 1'b0;
    @(posedge CLK);
    chk(exp_q.size() == 0, "reads left unanswered");
    $display("test unmapped access done");
    end_sim;
  end
endmodule : tb_pmrc_top

`default_nettype wire
